// ### inc/imc_pkg.sv
package imc_pkg;
    // Register word addresses on the Avalon-MM slave (one index per 32-bit register).
    localparam logic [3:0] OFS_DATA   = 4'h0;
    localparam logic [3:0] OFS_TARGET = 4'h1;
    localparam logic [3:0] OFS_CMD    = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_CTRL   = 4'h4;
    localparam logic [3:0] OFS_DIV    = 4'h5;
    localparam logic [3:0] OFS_IRQ    = 4'h6;
    localparam logic [3:0] OFS_MASK   = 4'h7;
    localparam logic [3:0] OFS_MIS    = 4'h8;

    // Command bit layout: run, start, stop, ack, receive.
    localparam int CB_RUN   = 0;
    localparam int CB_START = 1;
    localparam int CB_STOP  = 2;
    localparam int CB_ACK   = 3;
    localparam int CB_RECV  = 4;
    localparam logic [4:0] CMD_SINGLE_SEND      = 5'h07;
    localparam logic [4:0] CMD_SINGLE_RECEIVE   = 5'h17;
    localparam logic [4:0] CMD_MULTI_WRITE_FIRST = 5'h03;
    localparam logic [4:0] CMD_MULTI_WRITE_NEXT  = 5'h01;
    localparam logic [4:0] CMD_MULTI_WRITE_LAST  = 5'h05;
    localparam logic [4:0] CMD_MULTI_WRITE_ABORT = 5'h04;
    localparam logic [4:0] CMD_MULTI_READ_FIRST  = 5'h1b;
    localparam logic [4:0] CMD_MULTI_READ_NEXT   = 5'h19;
    localparam logic [4:0] CMD_MULTI_READ_LAST   = 5'h15;
    localparam logic [4:0] CMD_MULTI_READ_ABORT  = 5'h14;

    localparam logic [1:0] ERR_NONE             = 2'h0;
    localparam logic [1:0] ERR_ADDRESS_NACK     = 2'h1;
    localparam logic [1:0] ERR_DATA_NACK        = 2'h2;
    localparam logic [1:0] ERR_ARBITRATION_LOST = 2'h3;

    // Status register bit positions.
    localparam int SB_ENGINE_BUSY = 0;
    localparam int SB_BUS_OCCUPIED = 1;
    localparam int SB_ERR_LO      = 2;

    localparam int  CLOCK_HZ        = 200_000_000;
    localparam int  RATE_STD_HZ     = 100_000;
    localparam int  RATE_FAST_HZ    = 400_000;
    // One bit time is four quarter phases.
    localparam int  QUARTERS_PER_BIT = 4;
    localparam logic [15:0] DIV_STD_RESET =
        16'(CLOCK_HZ / (RATE_STD_HZ * QUARTERS_PER_BIT));

    typedef enum logic [6:0] {
        IMC_IDLE  = 7'h01,
        IMC_START = 7'h02,
        IMC_ADDR  = 7'h04,
        IMC_DATA  = 7'h08,
        IMC_ACK   = 7'h10,
        IMC_STOP  = 7'h20,
        IMC_HOLD  = 7'h40
    } imc_state_e;
endpackage

// ### logic/imc_tick.sv
`timescale 1ns/1ps
module imc_tick #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic             i_run,
    input  wire logic [WIDTH-1:0] i_divisor,
    output logic                  o_tick
);
    logic [WIDTH-1:0] count;

    initial begin
        if (WIDTH < 2) $error("imc_tick width too small");
    end

    // A divisor of zero is treated as one so the engine never stalls forever.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (count + WIDTH'(1) >= i_divisor) begin
            count  <= '0;
            o_tick <= 1'b1;
        end else begin
            count  <= count + WIDTH'(1);
            o_tick <= 1'b0;
        end
    end
endmodule

// ### logic/imc_bus_watch.sv
`timescale 1ns/1ps
module imc_bus_watch (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_occupied
);
    logic scl_q;
    logic sda_q;

    // Pins are synchronous; a start is SDA falling with SCL high, a stop SDA rising.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            o_occupied <= 1'b0;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            if (scl_q && i_scl && sda_q && !i_sda) begin
                o_occupied <= 1'b1;
            end else if (scl_q && i_scl && !sda_q && i_sda) begin
                o_occupied <= 1'b0;
            end
        end
    end
endmodule

// ### logic/imc_master.sv
// Behaviour
// [RULE1] Bus occupied flag tracks any master's traffic.
// [RULE2] Engine busy while own transfer runs.
// [RULE3] Ten single and burst command codes accepted.
// [RULE4] One error code reported per operation.
// [RULE5] Data read returns last received byte.
// [RULE6] Data write stores next byte to send.
// [RULE7] Serial clock 400 kbps fast, else 100.
// [RULE8] Divider programmed first, then engine enabled; here a control write reloads the divisor, so it is programmed after.
// [RULE9] Bit timing derived from the module clock.
// [RULE10] Cleared enable halts all master operation.
// [RULE11] Interrupt clear drops the latched source.
// [RULE12] Mask bit gates interrupt to processor.
// [RULE13] Software clears interrupt early in handler.
// [RULE14] Interrupt on completion or error abort.
// [RULE15] Start commands arbitrate, start, send address.
// [RULE16] Seven-bit target with read/write direction bit.
// [RULE17] Raw and masked interrupt status readable.
// [RULE18] Finish sends last byte; error-stop stops.
`timescale 1ns/1ps
module imc_master
    import imc_pkg::*;
#(
    parameter int DIV_WIDTH = 16
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_scl_oe,
    output logic             o_sda_oe,
    output logic             o_scl_out,
    output logic             o_sda_out,
    output logic             o_irq
);
    initial begin
        if (DIV_WIDTH < 8 || DIV_WIDTH > 16) $error("imc_master divider width unsupported");
    end

    imc_state_e       state;
    logic [7:0]       tx_byte;
    logic [7:0]       rx_byte;
    logic [6:0]       target;
    logic             recv_dir;
    logic [4:0]       cmd;
    logic             enable;
    logic             fast_speed_select;
    logic [15:0]      divisor;
    logic [1:0]       err;
    logic             irq_raw;
    logic             irq_mask;
    logic             answered;
    logic [7:0]       shift;
    logic [2:0]       bit_cnt;
    logic [1:0]       phase;
    logic             tick;
    logic             occupied;
    logic             done_evt;
    logic             cmd_go;
    logic             drive_sda;
    logic             ack_in;
    logic             shift_was_addr;

    wire logic wr_hit = i_write && !answered;
    wire logic rd_hit = i_read && !answered;
    // Waiting between burst bytes is not busy, so software can load the next byte.
    wire logic busy   = (state != IMC_IDLE) && (state != IMC_HOLD);

    // Every access is answered on the second edge: waitrequest falls for one cycle.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            answered      <= 1'b0;
            o_waitrequest <= 1'b1;
        end else begin
            answered      <= (i_read || i_write) && !answered;
            o_waitrequest <= !((i_read || i_write) && !answered);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_readdata <= '0;
        end else if (rd_hit) begin
            unique case (i_address)
                OFS_DATA:   o_readdata <= {24'h000000, rx_byte};  // see [RULE5]
                OFS_TARGET: o_readdata <= {24'h000000, recv_dir, target};
                OFS_CMD:    o_readdata <= {27'h0000000, cmd};
                OFS_STATUS: o_readdata <= {28'h0000000, err, occupied, busy};  // see [RULE1] see [RULE2] see [RULE4]
                OFS_CTRL:   o_readdata <= {30'h00000000, fast_speed_select, enable};
                OFS_DIV:    o_readdata <= {16'h0000, divisor};
                OFS_IRQ:    o_readdata <= {31'h00000000, irq_raw};  // see [RULE17]
                OFS_MASK:   o_readdata <= {31'h00000000, irq_mask};
                OFS_MIS:    o_readdata <= {31'h00000000, irq_raw & irq_mask};  // see [RULE17]
                default:    o_readdata <= '0;
            endcase
        end
    end

    // Writing the speed select loads the matching divisor; software may then override it.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable            <= 1'b0;
            fast_speed_select <= 1'b0;
            divisor           <= DIV_STD_RESET;
            irq_mask          <= 1'b0;
            target            <= '0;
            recv_dir          <= 1'b0;
            tx_byte           <= '0;
        end else if (wr_hit) begin
            if (i_address == OFS_CTRL) begin
                enable            <= i_writedata[0];  // see [RULE8] see [RULE10]
                fast_speed_select <= i_writedata[1];
                divisor <= i_writedata[1] ? 16'(CLOCK_HZ / (RATE_FAST_HZ * QUARTERS_PER_BIT))
                                          : DIV_STD_RESET;  // see [RULE7] see [RULE9]
            end
            if (i_address == OFS_DIV) divisor <= i_writedata[15:0];
            if (i_address == OFS_MASK) irq_mask <= i_writedata[0];  // see [RULE12]
            if (i_address == OFS_TARGET) begin
                target   <= i_writedata[6:0];  // see [RULE16]
                recv_dir <= i_writedata[7];
            end
            if (i_address == OFS_DATA && !busy) tx_byte <= i_writedata[7:0];  // see [RULE6]
        end
    end

    // A command is taken only while enabled and idle, or between burst bytes.
    assign cmd_go = wr_hit && i_address == OFS_CMD && enable && (state == IMC_IDLE || state == IMC_HOLD);

    imc_tick #(
        .WIDTH(16)
    ) u_tick (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_run    (enable && busy),
        .i_divisor(divisor),
        .o_tick   (tick)
    );

    imc_bus_watch u_watch (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .o_occupied(occupied)
    );

    assign ack_in = !i_sda;

    // Open-drain pins: the engine only ever drives low.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= IMC_IDLE;
            cmd       <= '0;
            shift     <= '0;
            bit_cnt   <= '0;
            phase     <= '0;
            err       <= ERR_NONE;
            rx_byte   <= '0;
            o_scl_oe  <= 1'b0;
            o_sda_oe  <= 1'b0;
            drive_sda <= 1'b0;
            done_evt  <= 1'b0;
        end else begin
            done_evt <= 1'b0;
            if (!enable) begin
                state    <= IMC_IDLE;  // see [RULE10]
                o_scl_oe <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (cmd_go) begin
                cmd   <= i_writedata[4:0];  // see [RULE3]
                phase <= '0;
                err   <= ERR_NONE;
                if (i_writedata[CB_START]) begin
                    if (occupied && state == IMC_IDLE) begin
                        err      <= ERR_ARBITRATION_LOST;  // see [RULE15]
                        done_evt <= 1'b1;
                    end else begin
                        state <= IMC_START;
                        shift <= {target, recv_dir};  // see [RULE16]
                    end
                end else if (i_writedata[CB_RUN]) begin
                    state   <= IMC_DATA;
                    shift   <= tx_byte;
                    bit_cnt <= '0;
                end else if (i_writedata[CB_STOP]) begin
                    state <= IMC_STOP;  // see [RULE18]
                end
            end else if (tick && !(phase == 2'h2 && !i_scl)) begin
                // A target stretching the clock stalls the engine before sampling.
                phase <= phase + 2'h1;
                unique case (state)
                    IMC_START: begin
                        if (phase == 2'h1) o_sda_oe <= 1'b1;
                        if (phase == 2'h3) begin
                            o_scl_oe <= 1'b1;
                            state    <= IMC_ADDR;  // see [RULE15]
                            bit_cnt  <= '0;
                        end
                    end
                    IMC_ADDR, IMC_DATA: begin
                        if (phase == 2'h0) begin
                            drive_sda <= (state == IMC_DATA && cmd[CB_RECV]) ? 1'b0 : !shift[7];
                            o_sda_oe  <= (state == IMC_DATA && cmd[CB_RECV]) ? 1'b0 : !shift[7];
                        end
                        if (phase == 2'h1) o_scl_oe <= 1'b0;
                        if (phase == 2'h2 && drive_sda == 1'b0 && !i_sda
                            && !(state == IMC_DATA && cmd[CB_RECV])) begin
                            err      <= ERR_ARBITRATION_LOST;  // see [RULE4]
                            state    <= IMC_IDLE;
                            o_sda_oe <= 1'b0;
                            done_evt <= 1'b1;  // see [RULE14]
                        end else if (phase == 2'h2) begin
                            shift <= {shift[6:0], i_sda};
                        end
                        if (phase == 2'h3) begin
                            o_scl_oe <= 1'b1;
                            bit_cnt  <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) state <= IMC_ACK;
                        end
                    end
                    IMC_ACK: begin
                        if (phase == 2'h0) begin
                            o_sda_oe <= cmd[CB_RECV] && bit_cnt == 3'h0 && cmd[CB_ACK] && !shift_was_addr;
                        end
                        if (phase == 2'h1) o_scl_oe <= 1'b0;
                        if (phase == 2'h2) begin
                            if (shift_was_addr) begin
                                if (!ack_in) err <= ERR_ADDRESS_NACK;
                            end else if (!cmd[CB_RECV]) begin
                                if (!ack_in) err <= ERR_DATA_NACK;
                            end else begin
                                rx_byte <= shift;  // see [RULE5]
                            end
                        end
                        if (phase == 2'h3) begin
                            o_scl_oe <= 1'b1;
                            if (err != ERR_NONE) begin
                                state <= IMC_STOP;  // see [RULE14]
                            end else if (shift_was_addr && cmd[CB_RUN]) begin
                                state   <= IMC_DATA;
                                shift   <= tx_byte;
                                bit_cnt <= '0;
                            end else if (cmd[CB_STOP]) begin
                                state <= IMC_STOP;  // see [RULE18]
                            end else begin
                                state    <= IMC_HOLD;
                                done_evt <= 1'b1;  // see [RULE2] see [RULE14]
                            end
                        end
                    end
                    IMC_STOP: begin
                        if (phase == 2'h0) o_sda_oe <= 1'b1;
                        if (phase == 2'h1) o_scl_oe <= 1'b0;
                        if (phase == 2'h3) begin
                            o_sda_oe <= 1'b0;
                            state    <= IMC_IDLE;
                            done_evt <= 1'b1;  // see [RULE14]
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // The address byte is acknowledged before any data; track which byte just ended.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_was_addr <= 1'b0;
        end else if (state == IMC_START) begin
            shift_was_addr <= 1'b1;
        end else if (state == IMC_DATA) begin
            shift_was_addr <= 1'b0;
        end
    end

    assign o_scl_out = 1'b0;
    assign o_sda_out = 1'b0;

    // The set wins over a same-cycle write-one-to-clear, so no completion is lost.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_raw <= 1'b0;
        end else if (done_evt) begin
            irq_raw <= 1'b1;  // see [RULE14]
        end else if (wr_hit && i_address == OFS_IRQ && i_writedata[0]) begin
            irq_raw <= 1'b0;  // see [RULE11] see [RULE13]
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_raw && irq_mask;  // see [RULE12]
        end
    end

    irq_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        done_evt |=> irq_raw) else $error("completion did not latch interrupt");  // see [RULE14]
    irq_mask_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (irq_raw && irq_mask) |=> ##0 (o_irq || $past(done_evt) || !irq_raw))
        else $error("masked interrupt missing");  // see [RULE12]
    irq_block_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !irq_mask |=> !o_irq) else $error("interrupt passed while masked");  // see [RULE12]
    irq_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (wr_hit && i_address == OFS_IRQ && i_writedata[0] && !done_evt) |=> !irq_raw)
        else $error("clear did not drop interrupt");  // see [RULE11]
    off_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !enable |=> (state == IMC_IDLE)) else $error("engine ran while disabled");  // see [RULE10]
    bus_answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ((i_read || i_write) && o_waitrequest) |-> ##[0:1] !o_waitrequest)
        else $error("bus access not answered");  // see [RULE2]
    start_go_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cmd_go && i_writedata[CB_START] && !occupied && state == IMC_IDLE) |=> state == IMC_START)
        else $error("start command not taken");  // see [RULE15]
    data_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (wr_hit && i_address == OFS_DATA && !busy) |=> tx_byte == $past(i_writedata[7:0]))
        else $error("transmit byte not stored");  // see [RULE6]

    cmd_cov: cover property (@(posedge i_clock) disable iff (!i_rst_n) cmd_go);
    done_cov: cover property (@(posedge i_clock) disable iff (!i_rst_n) done_evt && err == ERR_NONE);
    nack_cov: cover property (@(posedge i_clock) disable iff (!i_rst_n) err == ERR_ADDRESS_NACK);
endmodule

// ### test/imc_slave_model.sv
`timescale 1ns/1ps
module imc_slave_model #(
    parameter logic [6:0] ADDR = 7'h55
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_nack_data,
    input  wire logic       i_stretch,
    input  wire logic [7:0] i_read_seed,
    output logic            o_sda_oe,
    output logic            o_scl_oe,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_rx
);
    logic       scl_q;
    logic       sda_q;
    logic       act;
    logic       first;
    logic       rd;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [4:0] hold;
    // Bus edges are seen through the system clock, so every bus phase must last two cycles or more.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {scl_q, sda_q} <= 2'h3;
            {act, first, rd, o_sda_oe, o_scl_oe, bitn, sh, tx, hold, o_addr, o_rx} <= '0;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            o_scl_oe <= hold != 5'h0;
            if (hold != 5'h0) hold <= hold - 5'h1;
            if (i_scl && scl_q && sda_q && !i_sda) begin
                act <= 1'b1;
                first <= 1'b1;
                rd <= 1'b0;
                bitn <= 4'h0;
            end else if (i_scl && scl_q && !sda_q && i_sda) begin
                act <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (act && i_scl && !scl_q) begin
                if (bitn != 4'h8) sh <= {sh[6:0], i_sda};
                else if (rd && !first && i_sda) act <= 1'b0;
                bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
            end else if (act && !i_scl && scl_q) begin
                // A slow slave holds the clock low after each falling edge.
                hold <= i_stretch ? 5'h14 : 5'h0;
                if (bitn == 4'h8 && first) begin
                    o_addr <= sh;
                    rd <= sh[0];
                    first <= 1'b0;
                    tx <= i_read_seed;
                    o_sda_oe <= sh[7:1] == ADDR;
                    act <= sh[7:1] == ADDR;
                end else if (bitn == 4'h8) begin
                    o_sda_oe <= !rd && !i_nack_data;
                    if (!rd) o_rx <= sh;
                    if (rd) tx <= tx + 8'h1;
                end else begin
                    o_sda_oe <= rd && !tx[3'(4'h7 - bitn)];
                end
            end
        end
    end
endmodule

// ### test/tb_i2c_master_controller.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb_i2c_master_controller;
    import imc_pkg::*;
    localparam logic [6:0] SLV = 7'h55;
    localparam logic [4:0] SEQ [12] = '{CMD_SINGLE_SEND, CMD_MULTI_WRITE_FIRST, CMD_MULTI_WRITE_NEXT,
        CMD_MULTI_WRITE_LAST, CMD_MULTI_WRITE_FIRST, CMD_MULTI_WRITE_ABORT, CMD_SINGLE_RECEIVE,
        CMD_MULTI_READ_FIRST, CMD_MULTI_READ_NEXT, CMD_MULTI_READ_LAST, CMD_MULTI_READ_FIRST, CMD_MULTI_READ_ABORT};
    logic        i_clock;
    logic        i_rst_n;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        scl_oe;
    logic        sda_oe;
    logic        s_scl_oe;
    logic        s_sda_oe;
    logic        irq;
    logic        rogue;
    logic        nack;
    logic        stretch;
    logic        mask;
    logic [7:0]  seed;
    logic [7:0]  addr_seen;
    logic [7:0]  rx_seen;
    logic [7:0]  last;
    logic [7:0]  b;
    logic [4:0]  c;
    logic [31:0] rdq;
    int          num_errors;
    int          num_checks;
    int          cycles;
    int          per;
    int          q;
    int          k;
    wire         scl = !(scl_oe || s_scl_oe);
    wire         sda = !(sda_oe || s_sda_oe || rogue);
    imc_master u_imc_master (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(address), .i_read(read),
        .i_write(write), .i_writedata(writedata), .o_readdata(readdata), .o_waitrequest(waitrequest),
        .i_scl(scl), .i_sda(sda), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .o_scl_out(), .o_sda_out(), .o_irq(irq));
    imc_slave_model #(.ADDR(SLV)) u_imc_slave_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl),
        .i_sda(sda), .i_nack_data(nack), .i_stretch(stretch), .i_read_seed(seed), .o_sda_oe(s_sda_oe),
        .o_scl_oe(s_scl_oe), .o_addr(addr_seen), .o_rx(rx_seen));
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge i_clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rdq = readdata;
        if (n >= 50) num_errors++;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdq, e)
    endtask
    task automatic lvl(input logic v, inout int n);
        while (scl !== v && n < 9000) begin
            @(posedge i_clock);
            n++;
        end
    endtask
    task automatic go(input logic [7:0] t, input logic [4:0] cm, input logic [1:0] e, input logic o, input logic arb);
        int n;
        n = 0;
        stretch <= 1'($urandom);
        bus(1'b1, OFS_TARGET, {24'h0, t});
        bus(1'b1, OFS_CMD, {27'h0, cm});
        while (arb && sda_oe !== 1'b1 && n < 500) begin
            @(posedge i_clock);
            n++;
        end
        rogue <= arb;
        rdc(OFS_STATUS, {30'h0, !cm[CB_START] || arb, 1'b1});
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rdq[SB_ENGINE_BUSY] !== 1'b0 && n < 3000);
        // Occupancy follows the stop one cycle after busy falls.
        bus(1'b0, OFS_STATUS, 32'h0);
        rogue <= 1'b0;
        `CHK(rdq[SB_ERR_LO+:2], e)
        `CHK(rdq[SB_BUS_OCCUPIED], o)
        `CHK(irq, mask)
        rdc(OFS_IRQ, 32'h1);
        rdc(OFS_MIS, {31'h0, mask});
        // Clearing right after the status reads keeps a handler from seeing the same event twice.
        bus(1'b1, OFS_IRQ, 32'h1);
        repeat (3) @(posedge i_clock);
        `CHK(irq, 1'b0)
    endtask
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = !i_clock;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        {i_rst_n, read, write, rogue, nack, stretch, mask, address, writedata, seed} = '0;
        {num_errors, num_checks, cycles, k} = '0;
        void'($urandom(30195));
        repeat (16) @(posedge i_clock);
        `CHK({scl_oe, sda_oe, irq}, 3'h0)
        i_rst_n <= 1'b1;
        rdc(OFS_STATUS, 32'h0);
        rdc(OFS_MASK, 32'h0);
        rdc(OFS_DIV, {16'h0, DIV_STD_RESET});
        rdc(4'hf, 32'h0);
        $display("test reset done");
        bus(1'b1, OFS_TARGET, {25'h0, SLV});
        for (int f = 1; f >= 0; f--) begin
            q = CLOCK_HZ / (f ? RATE_FAST_HZ : RATE_STD_HZ);
            bus(1'b1, OFS_CTRL, {30'h0, f[0], 1'b1});
            rdc(OFS_DIV, 32'(q / QUARTERS_PER_BIT));
            bus(1'b1, OFS_CMD, {27'h0, CMD_SINGLE_SEND});
            per = 0;
            lvl(1'b0, per);
            lvl(1'b1, per);
            per = 0;
            lvl(1'b0, per);
            lvl(1'b1, per);
            `CHK(per inside {[q - q / 50 : q + q / 50]}, 1'b1)
            bus(1'b1, OFS_CTRL, 32'h0);
            bus(1'b1, OFS_CMD, {27'h0, CMD_SINGLE_SEND});
            repeat (40) @(posedge i_clock);
            `CHK({scl_oe, sda_oe}, 2'h0)
            rogue <= 1'b1;
            repeat (20) @(posedge i_clock);
            bus(1'b0, OFS_STATUS, 32'h0);
            `CHK(rdq[1:0], 2'h2)
            rogue <= 1'b0;
            repeat (20) @(posedge i_clock);
            bus(1'b0, OFS_STATUS, 32'h0);
            `CHK(rdq[1:0], 2'h0)
        end
        $display("test speed done");
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b1, OFS_DIV, 32'h4);
        bus(1'b1, OFS_MASK, 32'h1);
        mask <= 1'b1;
        foreach (SEQ[i]) begin
            c = SEQ[i];
            b = 8'($urandom);
            // Read bytes start with a one, since a slave driving a zero would block the stop.
            if (c[CB_START]) seed <= {2'h2, b[5:0]};
            if (c[CB_START]) k = 0;
            bus(1'b1, OFS_DATA, {24'h0, b});
            go({c[CB_RECV], SLV}, c, ERR_NONE, !c[CB_STOP], 1'b0);
            `CHK(addr_seen, {SLV, c[CB_RECV]})
            if (!c[CB_RECV] && c[CB_RUN]) last = b;
            if (!c[CB_RECV]) `CHK(rx_seen, last)
            if (c[CB_RECV] && c[CB_RUN]) rdc(OFS_DATA, {24'h0, 8'(seed + k)});
            k++;
        end
        $display("test commands done");
        go({1'b0, ~SLV}, CMD_SINGLE_SEND, ERR_ADDRESS_NACK, 1'b0, 1'b0);
        nack <= 1'b1;
        go({1'b0, SLV}, CMD_SINGLE_SEND, ERR_DATA_NACK, 1'b0, 1'b0);
        nack <= 1'b0;
        go({1'b0, SLV}, CMD_SINGLE_SEND, ERR_ARBITRATION_LOST, 1'b1, 1'b1);
        $display("test errors done");
        bus(1'b1, OFS_MASK, 32'h0);
        mask <= 1'b0;
        go({1'b0, SLV}, CMD_SINGLE_SEND, ERR_NONE, 1'b0, 1'b0);
        $display("test mask done");
        test_done();
    end
endmodule
